/* File: bench/mwc_mem_model.sv */
`timescale 1ns/1ns
// Message memory: the read answers in the same cycle, writes land on the edge.
module mwc_mem_model (
  // Clock.
  input  wire logic                 clk_i,
  // Memory port.
  input  wire logic [23:0]          rd_addr_i,
  output logic [7:0]                rd_data_o,
  input  wire mwc_pkg::mwc_mem_wr_t wr_i
);
  import mwc_pkg::*;
  logic [7:0] mem [256];
  // Only the low byte decodes, which is enough for the small test blocks.
  assign rd_data_o = mem[rd_addr_i[7:0]];
  // Plain always so the bench may preload the array at time zero.
  always @(posedge clk_i)
  begin
    if (wr_i.valid)
      mem[wr_i.addr[7:0]] <= wr_i.data;
  end
endmodule

/* File: bench/tb_mwc_write_cmd.sv */
`timescale 1ns/1ns
module tb_mwc_write_cmd;
  import mwc_pkg::*;
  logic        clk, rst, stop, mdef, sel, alloc, open, err;
  logic [23:0] rda;
  logic [7:0]  rdd, ecode, pay, exp_mem [256];
  mwc_byte_t   rx, echo;
  mwc_mem_wr_t wr;
  logic [7:0]  echo_q [$];
  int          n_fail, total_checks, n_err, n_alloc;
  mwc_write_cmd #(.BLOCK_BYTES(64)) mwc_write_cmd_i (.clk_i(clk),
    .rst_i(rst), .rx_i(rx), .echo_o(echo), .stop_i(stop),
    .msg_defined_i(mdef), .msg_start_i(24'h000040), .select_i(sel),
    .select_addr_i(24'h000080), .new_block_i(24'h0000C0),
    .alloc_req_o(alloc), .rd_addr_o(rda), .rd_data_i(rdd),
    .mem_wr_o(wr), .open_o(open), .err_o(err), .err_code_o(ecode));
  mwc_mem_model mwc_mem_model_i (.clk_i(clk), .rd_addr_i(rda),
    .rd_data_o(rdd), .wr_i(wr));
  // Compare and count; an unknown matches only the same unknown.
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One host byte per cycle, noting its echo when one is due.
  task automatic put(logic [7:0] b, bit echoed);
    @(negedge clk);
    rx = {1'b1, b};
    if (echoed)
      echo_q.push_back(b);
  endtask
  task automatic idle(int n);
    @(negedge clk);
    rx = '0;
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    idle(2);
  endtask
  // Opcode and 32 payload bytes back to back; memory may only lose ones.
  task automatic write_message_command(logic [23:0] base, bit ones);
    put(8'h31, 1'b1);
    for (int i = 0; i < 32; i++)
    begin
      pay = ones ? 8'hFF : 8'($urandom);
      put(pay, 1'b1);
      exp_mem[8'(base + i)] &= pay;
    end
    idle(3);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Results appear one cycle after the byte and are sampled mid-cycle,
  // away from the edge that launches them; the oldest note is compared.
  always @(negedge clk)
  begin
    if (echo.valid === 1'b1)
      chk("echo", echo_q.size() ? echo_q.pop_front() : 'x, echo.data);
    if (err === 1'b1)
    begin
      n_err++;
      chk("err_code", 8'h01, ecode);
    end
    if (alloc === 1'b1)
      n_alloc++;
  end
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h0AA92091));
    {rst, stop, mdef, sel, rx} = {1'b1, 12'h000};
    for (int a = 0; a < 256; a++)
    begin
      exp_mem[a] = 8'($urandom);
      mwc_mem_model_i.mem[a] = exp_mem[a];
    end
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // A stray byte while waiting gets no echo.
    put(8'h5A, 1'b0);
    put(8'h31, 1'b1);
    idle(4);
    chk("err_count", 1, n_err);
    chk("open", 0, open);
    mdef = 1'b1;
    write_message_command(24'h000040, 1'b0);
    chk("open", 1, open);
    write_message_command(24'h000060, 1'b0);
    chk("alloc", 1, n_alloc);
    pulse(stop);
    chk("open", 0, open);
    pulse(sel);
    write_message_command(24'h000080, 1'b1);
    write_message_command(24'h0000C0, 1'b0);
    chk("alloc", 2, n_alloc);
    for (int a = 0; a < 256; a++)
      chk("mem", exp_mem[a], mwc_mem_model_i.mem[a]);
    chk("echo_left", 0, echo_q.size());
    tally_and_finish();
  end
endmodule

/* File: logic/mwc_defines.svh */
`ifndef MWC_DEFINES_SVH
`define MWC_DEFINES_SVH
// Opcode and payload geometry of the message write command.
`define MWC_OPCODE        8'h31
`define MWC_PAYLOAD_BYTES 6'h20
`define MWC_LAST_BYTE     5'h1F
`define MWC_ERASED_BYTE   8'hFF
// Default geometry of one memory block, in bytes.
`define MWC_BLOCK_BYTES   4096
// Error code reported when no message is current.
`define MWC_ERR_INVALID   8'h01
`endif

/* File: logic/mwc_pkg.sv */
package mwc_pkg;
  // Control state of the message engine.
  typedef enum logic [1:0] {
    MWC_IDLE = 2'b00,
    MWC_OPEN = 2'b01
  } mwc_msg_t;

  // Command receive state, Gray coded along opcode, payload, commit.
  typedef enum logic [1:0] {
    MWC_WAIT_OP  = 2'b00,
    MWC_PAYLOAD  = 2'b01,
    MWC_COMMIT   = 2'b11
  } mwc_cmd_t;

  // One byte on the serial host link, with its valid flag.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mwc_byte_t;

  // Byte write request toward message memory.
  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [7:0]  data;
  } mwc_mem_wr_t;
endpackage

/* File: logic/mwc_write_cmd.sv */
`timescale 1ns/1ns
`include "mwc_defines.svh"
// Notes on behaviour
// - Store 32 bytes at pointer, advance 32.
// - Idle write opens message, pointer to start.
// - All-ones payload leaves page unchanged.
// - Write after all-ones starts new block.
// - Stop command closes message, returns idle.
// - Stored bits only cleared, never set.
// - No current message reports invalid error.
// - Echo opcode and 32 data bytes in order.
module mwc_write_cmd #(
  parameter int ADDR_W      = 24,
  parameter int BLOCK_BYTES = `MWC_BLOCK_BYTES
) (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Host byte link, already on clk_i.
  input  wire mwc_pkg::mwc_byte_t  rx_i,
  output mwc_pkg::mwc_byte_t       echo_o,
  // Stop command and message context from the command core.
  input  wire logic                stop_i,
  input  wire logic                msg_defined_i,
  input  wire logic [ADDR_W-1:0]   msg_start_i,
  input  wire logic                select_i,
  input  wire logic [ADDR_W-1:0]   select_addr_i,
  // Block allocator.
  input  wire logic [ADDR_W-1:0]   new_block_i,
  output logic                     alloc_req_o,
  // Message memory, read-modify-write path.
  output logic [ADDR_W-1:0]        rd_addr_o,
  input  wire logic [7:0]          rd_data_i,
  output mwc_pkg::mwc_mem_wr_t     mem_wr_o,
  // Status.
  output logic                     open_o,
  output logic                     err_o,
  output logic [7:0]               err_code_o
);
  import mwc_pkg::*;

  localparam int OFF_W = $clog2(BLOCK_BYTES);

  mwc_msg_t           msg_reg, msg_next;
  mwc_cmd_t           cmd_reg, cmd_next;
  logic [ADDR_W-1:0]  ptr_reg, ptr_next;
  logic [4:0]         cnt_reg, cnt_next;
  logic               ones_reg, ones_next;
  logic               pend_reg, pend_next;
  mwc_byte_t          echo_reg, echo_next;
  mwc_mem_wr_t        wr_reg, wr_next;
  logic               err_reg, err_next;
  logic               alloc_reg, alloc_next;

  // Offset of an address within its block.
  function automatic logic [OFF_W-1:0] blk_off(input logic [ADDR_W-1:0] a);
    blk_off = a[OFF_W-1:0];
  endfunction

  // Reads are combinational so the clear-only merge sees current data.
  assign rd_addr_o = ptr_reg;

  // Next-state logic for the whole command engine.
  always_comb
  begin
    msg_next   = msg_reg;
    cmd_next   = cmd_reg;
    ptr_next   = ptr_reg;
    cnt_next   = cnt_reg;
    ones_next  = ones_reg;
    pend_next  = pend_reg;
    echo_next  = '0;
    wr_next    = '0;
    err_next   = 1'b0;
    alloc_next = 1'b0;
    // Selecting a page while no message is open sets the pointer there ahead of an append.
    if (select_i && msg_reg == MWC_IDLE)
    begin
      ptr_next  = select_addr_i;
      msg_next  = MWC_OPEN;
      pend_next = 1'b0;
    end
    if (stop_i)
    begin
      msg_next  = MWC_IDLE;
      cmd_next  = MWC_WAIT_OP;
      pend_next = 1'b0;
    end
    else
    begin
      case (cmd_reg)
        MWC_WAIT_OP:
        begin
          if (rx_i.valid && rx_i.data == `MWC_OPCODE)
          begin
            echo_next = rx_i;
            if (!msg_defined_i)
              err_next = 1'b1;
            else
            begin
              cmd_next  = MWC_PAYLOAD;
              cnt_next  = '0;
              ones_next = 1'b1;
              if (msg_reg == MWC_IDLE)
              begin
                msg_next = MWC_OPEN;
                ptr_next = msg_start_i;
              end
              else if (pend_reg)
              begin
                // Previous payload was all ones: start a fresh block.
                ptr_next   = new_block_i;
                alloc_next = 1'b1;
                pend_next  = 1'b0;
              end
            end
          end
        end
        MWC_PAYLOAD:
        begin
          if (rx_i.valid)
          begin
            echo_next    = rx_i;
            wr_next.valid = 1'b1;
            wr_next.addr = ptr_reg;
            // Flash-style cells can only be cleared, so merge with old.
            wr_next.data = rx_i.data & rd_data_i;
            ones_next    = ones_reg && rx_i.data == `MWC_ERASED_BYTE;
            ptr_next     = ptr_reg + ADDR_W'(1);
            if (&blk_off(ptr_reg))
            begin
              ptr_next   = new_block_i;
              alloc_next = 1'b1;
            end
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == `MWC_LAST_BYTE)
              cmd_next = MWC_COMMIT;
          end
        end
        MWC_COMMIT:
        begin
          pend_next = ones_reg;
          cmd_next  = MWC_WAIT_OP;
        end
        default: cmd_next = MWC_WAIT_OP;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      msg_reg   <= MWC_IDLE;
      cmd_reg   <= MWC_WAIT_OP;
      ptr_reg   <= '0;
      cnt_reg   <= 5'h00;
      ones_reg  <= 1'b0;
      pend_reg  <= 1'b0;
      echo_reg  <= '0;
      wr_reg    <= '0;
      err_reg   <= 1'b0;
      alloc_reg <= 1'b0;
    end
    else
    begin
      msg_reg   <= msg_next;
      cmd_reg   <= cmd_next;
      ptr_reg   <= ptr_next;
      cnt_reg   <= cnt_next;
      ones_reg  <= ones_next;
      pend_reg  <= pend_next;
      echo_reg  <= echo_next;
      wr_reg    <= wr_next;
      err_reg   <= err_next;
      alloc_reg <= alloc_next;
    end
  end

  assign echo_o      = echo_reg;
  assign mem_wr_o    = wr_reg;
  assign open_o      = (msg_reg == MWC_OPEN);
  assign err_o       = err_reg;
  assign err_code_o  = err_reg ? `MWC_ERR_INVALID : 8'h00;
  assign alloc_req_o = alloc_reg;

  // Checks kept beside the logic.
  a_echo_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_i.valid && cmd_reg == MWC_PAYLOAD && !stop_i
      |=> echo_o.valid && echo_o.data == $past(rx_i.data))
    else $error("payload byte not echoed");
  a_clear_only: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_i.valid && cmd_reg == MWC_PAYLOAD && !stop_i
      |=> (mem_wr_o.data & ~$past(rd_data_i)) == 8'h00)
    else $error("stored zero bit set");
  a_ones_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_i.valid && rx_i.data == 8'hFF && cmd_reg == MWC_PAYLOAD && !stop_i
      |=> mem_wr_o.data == $past(rd_data_i))
    else $error("all-ones byte altered page");
  a_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_i |=> !open_o)
    else $error("stop did not close message");
  a_idle_open: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_reg == MWC_WAIT_OP && rx_i.valid && rx_i.data == 8'h31
      && msg_defined_i && !open_o && !stop_i
      |=> open_o && ptr_reg == $past(msg_start_i))
    else $error("idle write did not open message");
  a_err_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_reg == MWC_WAIT_OP && rx_i.valid && rx_i.data == 8'h31
      && !msg_defined_i && !stop_i
      |=> err_o && err_code_o == `MWC_ERR_INVALID && !mem_wr_o.valid)
    else $error("undefined message not refused");
  a_ptr_step: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_i.valid && cmd_reg == MWC_PAYLOAD && !stop_i
      && !(&blk_off(ptr_reg))
      |=> ptr_reg == $past(ptr_reg) + ADDR_W'(1))
    else $error("pointer did not advance");
  a_block_cross: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_i.valid && cmd_reg == MWC_PAYLOAD && !stop_i
      && (&blk_off(ptr_reg))
      |=> alloc_req_o && ptr_reg == $past(new_block_i))
    else $error("block crossing not continued");
endmodule
